// ==== common/iaqs_pkg.sv ====
// Constants for the input action and quick stop logic.
// Assumes a single 20 MHz clock and an 8-bit plain register port.
package iaqs_pkg;
  localparam int NUM_IN = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CFG_W = 6;

  // Register offsets (cfg of input n sits at REG_CFG0 + n)
  localparam logic [3:0] REG_CFG0 = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h5;
  localparam logic [3:0] REG_INS = 4'h6;

  // Input config fields
  localparam int CFG_ACT_LSB = 0;
  localparam int CFG_NC_BIT = 4;
  localparam int CFG_RET_BIT = 5;
  localparam logic [5:0] CFG_RESET = 6'h00;

  // Control register fields
  localparam int CTRL_CW = 0;
  localparam int CTRL_CCW = 1;
  localparam int CTRL_BRAKE = 2;
  localparam int CTRL_QS_DIS = 3;
  localparam int CTRL_BRK_MOTOR = 4;
  localparam int CTRL_ERR_CLR = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status register fields
  localparam int ST_CW = 0;
  localparam int ST_CCW = 1;
  localparam int ST_BRAKE = 2;
  localparam int ST_QS = 3;
  localparam int ST_MANUAL = 4;
  localparam int ST_COLD_TRIP = 5;
  localparam int ST_PARAM_ERR = 6;
  localparam int ST_TRIP = 7;

  // Input action codes
  localparam logic [3:0] ACT_NONE = 4'h0;
  localparam logic [3:0] ACT_MANUAL = 4'h1;
  localparam logic [3:0] ACT_MOTOR_CW = 4'h2;
  localparam logic [3:0] ACT_MOTOR_CCW = 4'h3;
  localparam logic [3:0] ACT_QUICK_STOP = 4'h4;
  localparam logic [3:0] ACT_TRIP_RESET = 4'h5;
  localparam logic [3:0] ACT_COLD_RUN = 4'h6;
endpackage : iaqs_pkg

// ==== common/iaqs_in_if.sv ====
// Conditioned digital inputs passed from the input conditioner to the core.
// Assumes both ends sit on sys_clk_i.
interface iaqs_in_if;
  logic [3:0] nc;
  logic [3:0] raw;
  logic [3:0] act;
  logic [3:0] act_edge;
  modport prod (input nc, output raw, output act, output act_edge);
  modport cons (output nc, input raw, input act, input act_edge);
endinterface : iaqs_in_if

// ==== hdl/iaqs_in_cond.sv ====
// Input conditioner: synchroniser, polarity and active edge per input.
// Assumes asynchronous pin inputs and a polarity setting from the core.
module iaqs_in_cond (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] din_i,
  iaqs_in_if.prod inp
);
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] act_q;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
    end else begin
      sync1 <= din_i;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      act_q <= 4'h0;
    end else begin
      act_q <= inp.act;
    end
  end

  // Report voltage as one whatever the contact polarity
  assign inp.raw = sync2;
  assign inp.act = sync2 ^ inp.nc;
  assign inp.act_edge = inp.act & ~act_q;

  a_edge_from_samples: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    (inp.act_edge != 4'h0) |-> ((inp.act_edge & act_q) == 4'h0)
  ) else $error("active edge without a low previous sample");

  a_raw_ignores_nc: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    inp.raw == $past(din_i, 2)
  ) else $error("reported input differs from synchronised pin");
endmodule : iaqs_in_cond

// ==== hdl/iaqs_top.sv ====
// Input action and quick stop logic of the motor starter core.
// Assumes switch inputs on pins, fieldbus commands in the control register,
// trip and group fault from same-clock logic, current sensing from a pin.
//
// The implementer's own choices: the address map and the plain strobed port.
module iaqs_top (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [3:0] din_i,
  input wire logic main_current_i,
  input wire logic group_fault_i,
  input wire logic trip_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic motor_cw_o,
  output logic motor_ccw_o,
  output logic brake_o,
  output logic qs_active_o,
  output logic trip_reset_o,
  output logic cold_trip_o,
  output logic cold_run_o,
  output logic manual_local_o,
  output logic [3:0] inputs_o
);
  logic [3:0][5:0] cfg;
  logic [7:0] ctrl;
  logic param_err;
  logic cur_s1;
  logic cur_s2;
  logic cw_latch;
  logic ccw_latch;
  logic qs_latch;
  logic [3:0] m_man;
  logic [3:0] m_cw;
  logic [3:0] m_ccw;
  logic [3:0] m_qs;
  logic [3:0] m_tr;
  logic [3:0] m_cold;
  logic [3:0] ret;
  logic manual_local;
  logic cw_lvl;
  logic ccw_lvl;
  logic cw_set;
  logic ccw_set;
  logic qs_dis;
  logic qs_level;
  logic qs_edge;
  logic qs_active;
  logic run_cw_req;
  logic run_ccw_req;
  logic trip_any;
  logic cold_run;
  logic next_cw;
  logic next_ccw;
  logic next_brake;
  logic cfg_wr;
  logic cfg_bad;

  iaqs_in_if inp ();

  iaqs_in_cond u_cond (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .din_i(din_i),
    .inp(inp)
  );

  // Mask of inputs whose configured action equals code
  function automatic logic [3:0] act_mask(input logic [3:0][5:0] c, input logic [3:0] code);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < iaqs_pkg::NUM_IN; i++) begin
      m[i] = (c[i][iaqs_pkg::CFG_ACT_LSB +: 4] == code);
    end
    return m;
  endfunction : act_mask

  // Polarity and signal settings that the device refuses
  function automatic logic cfg_invalid(input logic [7:0] d);
    logic [3:0] a;
    logic nc;
    a = d[iaqs_pkg::CFG_ACT_LSB +: 4];
    nc = d[iaqs_pkg::CFG_NC_BIT];
    cfg_invalid = (nc && (a == iaqs_pkg::ACT_MOTOR_CW || a == iaqs_pkg::ACT_MOTOR_CCW ||
                          a == iaqs_pkg::ACT_TRIP_RESET || a == iaqs_pkg::ACT_COLD_RUN)) ||
                  (d[iaqs_pkg::CFG_RET_BIT] && a == iaqs_pkg::ACT_TRIP_RESET);
  endfunction : cfg_invalid

  genvar gi;
  generate
    for (gi = 0; gi < iaqs_pkg::NUM_IN; gi++) begin : g_in
      assign inp.nc[gi] = cfg[gi][iaqs_pkg::CFG_NC_BIT];
      assign ret[gi] = cfg[gi][iaqs_pkg::CFG_RET_BIT];
    end
  endgenerate

  assign cfg_wr = wr_i && (addr_i < iaqs_pkg::REG_CTRL);
  assign cfg_bad = cfg_invalid(wdata_i);

  // A refused setting keeps the previous one so a run, trip reset or cold run input never runs NC
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg <= {4{iaqs_pkg::CFG_RESET}};
    end else if (cfg_wr && !cfg_bad) begin
      cfg[addr_i[1:0]] <= wdata_i[5:0];
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl <= iaqs_pkg::CTRL_RESET;
    end else if (wr_i && addr_i == iaqs_pkg::REG_CTRL) begin
      ctrl <= {1'b0, wdata_i[6:0]};
    end
  end

  // Set by a refused write wins over a clear in the same cycle
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      param_err <= 1'b0;
    end else if (cfg_wr && cfg_bad) begin
      param_err <= 1'b1;
    end else if (wr_i && addr_i == iaqs_pkg::REG_CTRL && wdata_i[iaqs_pkg::CTRL_ERR_CLR]) begin
      param_err <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i < iaqs_pkg::REG_CTRL) begin
        rdata_o <= {2'b00, cfg[addr_i[1:0]]};
      end else if (addr_i == iaqs_pkg::REG_CTRL) begin
        rdata_o <= ctrl;
      end else if (addr_i == iaqs_pkg::REG_STAT) begin
        rdata_o <= {trip_any, param_err, cold_trip_o, manual_local, qs_active,
                    brake_o, motor_ccw_o, motor_cw_o};
      end else if (addr_i == iaqs_pkg::REG_INS) begin
        rdata_o <= {4'h0, inp.raw};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cur_s1 <= 1'b0;
      cur_s2 <= 1'b0;
    end else begin
      cur_s1 <= main_current_i;
      cur_s2 <= cur_s1;
    end
  end

  assign m_man = act_mask(cfg, iaqs_pkg::ACT_MANUAL);
  assign m_cw = act_mask(cfg, iaqs_pkg::ACT_MOTOR_CW);
  assign m_ccw = act_mask(cfg, iaqs_pkg::ACT_MOTOR_CCW);
  assign m_qs = act_mask(cfg, iaqs_pkg::ACT_QUICK_STOP);
  assign m_tr = act_mask(cfg, iaqs_pkg::ACT_TRIP_RESET);
  assign m_cold = act_mask(cfg, iaqs_pkg::ACT_COLD_RUN);

  assign manual_local = |(m_man & inp.act);
  assign cw_lvl = |(m_cw & ~ret & inp.act);
  assign ccw_lvl = |(m_ccw & ~ret & inp.act);
  assign cw_set = |(m_cw & ret & inp.act);
  assign ccw_set = |(m_ccw & ret & inp.act);
  assign qs_dis = ctrl[iaqs_pkg::CTRL_QS_DIS];
  assign qs_level = |(m_qs & ~ret & inp.act) && !qs_dis;
  assign qs_edge = |(m_qs & ret & inp.act_edge);
  assign qs_active = qs_level || qs_latch;
  assign cold_run = |(m_cold & inp.act);
  assign trip_any = trip_i || cold_trip_o;

  // Retentive run latches; the cancel wins as the stop is a safety path
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cw_latch <= 1'b0;
      ccw_latch <= 1'b0;
    end else if (qs_active || group_fault_i || !manual_local) begin
      cw_latch <= 1'b0;
      ccw_latch <= 1'b0;
    end else begin
      cw_latch <= cw_latch || cw_set;
      ccw_latch <= ccw_latch || ccw_set;
    end
  end

  // Manual local hands the run commands to the local inputs alone
  always_comb begin
    if (manual_local) begin
      run_cw_req = cw_lvl || cw_latch;
      run_ccw_req = ccw_lvl || ccw_latch;
    end else begin
      run_cw_req = ctrl[iaqs_pkg::CTRL_CW];
      run_ccw_req = ctrl[iaqs_pkg::CTRL_CCW];
    end
  end

  // Edges under a held disable never latch, so a static level stays harmless
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      qs_latch <= 1'b0;
    end else if (qs_edge && !qs_dis) begin
      qs_latch <= 1'b1;
    end else if (qs_dis || !(run_cw_req || run_ccw_req)) begin
      qs_latch <= 1'b0;
    end
  end

  // Opposing commands both held is treated as no command
  always_comb begin
    next_cw = run_cw_req && !run_ccw_req && !qs_active && !trip_any;
    next_ccw = run_ccw_req && !run_cw_req && !qs_active && !trip_any;
    if (manual_local) begin
      next_brake = (next_cw || next_ccw) && ctrl[iaqs_pkg::CTRL_BRK_MOTOR];
    end else begin
      next_brake = (next_cw || next_ccw) && ctrl[iaqs_pkg::CTRL_BRAKE];
    end
  end

  // Quick stop drops the outputs and cancels the run latches; group fault is not touched
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      motor_cw_o <= 1'b0;
      motor_ccw_o <= 1'b0;
      brake_o <= 1'b0;
      qs_active_o <= 1'b0;
    end else begin
      motor_cw_o <= next_cw;
      motor_ccw_o <= next_ccw;
      brake_o <= next_brake;
      qs_active_o <= qs_active;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      trip_reset_o <= 1'b0;
    end else begin
      trip_reset_o <= |(m_tr & inp.act_edge);
    end
  end

  // Current while cold running is an internal trip until trip reset
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cold_trip_o <= 1'b0;
    end else if (cold_run && cur_s2) begin
      cold_trip_o <= 1'b1;
    end else if (trip_reset_o) begin
      cold_trip_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cold_run_o <= 1'b0;
      manual_local_o <= 1'b0;
      inputs_o <= 4'h0;
    end else begin
      cold_run_o <= cold_run;
      manual_local_o <= manual_local;
      inputs_o <= inp.raw;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_local_manual_only: assert property (
    $rose(motor_cw_o) && manual_local_o |-> $past(cw_lvl || cw_latch)
  ) else $error("local run acted without a local command");

  a_brake_param: assert property (
    motor_cw_o && $past(manual_local && ctrl[iaqs_pkg::CTRL_BRK_MOTOR]) |-> brake_o
  ) else $error("brake not applied with local run");

  a_brake_with_motor: assert property (
    !motor_cw_o && !motor_ccw_o |-> !brake_o
  ) else $error("brake on without motor");

  a_nc_run_refused: assert property (
    cfg_wr && cfg_bad |=> cfg == $past(cfg) && param_err
  ) else $error("refused setting was stored");

  a_cancel_latch: assert property (
    qs_active || group_fault_i |=> !cw_latch && !ccw_latch
  ) else $error("run latch survived quick stop or fault");

  a_qs_stops_motor: assert property (
    qs_active |=> !motor_cw_o && !motor_ccw_o && !brake_o
  ) else $error("motor on during quick stop");

  a_qs_edge_only: assert property (
    $rose(qs_latch) |-> $past(qs_edge && !qs_dis)
  ) else $error("quick stop latched without an edge");

  a_qs_clear: assert property (
    qs_dis || !(run_cw_req || run_ccw_req) ##0 !qs_edge |=> !qs_latch
  ) else $error("latched quick stop not cleared");

  a_trip_reset_once: assert property (
    trip_reset_o |=> !trip_reset_o
  ) else $error("trip reset longer than one cycle");

  a_cold_trip: assert property (
    cold_run && cur_s2 |=> cold_trip_o ##1 !motor_cw_o
  ) else $error("current in cold run did not trip");

  a_jog_follow: assert property (
    manual_local && cw_lvl && !run_ccw_req && !qs_active && !trip_any |=> motor_cw_o
  ) else $error("jog input not followed");

  a_qs_dis_masks: assert property (
    qs_dis && !qs_latch |=> !qs_latch
  ) else $error("edge under disable latched");

  a_level_qs: assert property (
    qs_level |=> !motor_cw_o
  ) else $error("motor on with level quick stop");

  c_qs_latch: cover property (run_cw_req ##1 $rose(qs_latch) ##[1:20] $fell(qs_latch));
  c_qs_dis_restart: cover property (qs_latch ##1 qs_dis ##[1:4] motor_cw_o);
  c_trip_reset: cover property (cold_trip_o ##[1:20] trip_reset_o);
  c_local_run: cover property (manual_local && $rose(motor_cw_o));
endmodule : iaqs_top

// ==== testbench/iaqs_master.sv ====
// Fieldbus master and local switch model: drives the register port and the pins.
// Assumes the slave never stalls and read data stand only in the cycle after the strobe.
module iaqs_master (
  input wire logic sys_clk_i,
  input wire logic [7:0] rdata_i,
  output logic [3:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  output logic [3:0] din_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 4'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    din_o = 4'h0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
  endtask : wr
  // Data are taken just after the take edge, the only cycle they stand
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask : rd
  // Switch levels; the block synchronises them itself
  task automatic pins(input logic [3:0] v);
    @(posedge sys_clk_i);
    din_o <= v;
  endtask : pins
endmodule : iaqs_master

// ==== testbench/input_action_quick_stop_logic_bench.sv ====
// Self-checking bench for the input action and quick stop logic.
// Assumes the master model for bus and switches; trip, fault and current driven here.
module input_action_quick_stop_logic_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mc = 1'b0;
  logic gf = 1'b0;
  logic tr = 1'b0;
  logic [3:0] addr, din, ins;
  logic [7:0] wdata, rdata, d;
  logic wr, rd, cw, ccw, brk, qs, trst, ctrip, crun, man;
  int err_count = 0;
  int num_checks = 0;
  int tr_cnt = 0;
  int n0;
  logic [31:0] seed, r;
  logic [7:0] bad_cfg [5] = '{8'h12, 8'h13, 8'h15, 8'h16, 8'h25};
  logic [7:0] cfg_m [4];
  logic ok;
  logic [3:0] ua;

  always #25 clk = ~clk;
  always @(posedge clk) if (trst === 1'b1) tr_cnt <= tr_cnt + 1;

  iaqs_top iaqs_top_inst (.sys_clk_i(clk), .reset_i(rst), .din_i(din), .main_current_i(mc),
    .group_fault_i(gf), .trip_i(tr), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .motor_cw_o(cw), .motor_ccw_o(ccw), .brake_o(brk), .qs_active_o(qs),
    .trip_reset_o(trst), .cold_trip_o(ctrip), .cold_run_o(crun), .manual_local_o(man),
    .inputs_o(ins));
  iaqs_master bus (.sys_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .din_o(din));

  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : w
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // NO-only actions refuse NC; trip reset also refuses the retentive setting
  function automatic logic cfg_ok(input logic [7:0] v);
    logic [3:0] a;
    logic no_only;
    a = v[3:0];
    no_only = (a == iaqs_pkg::ACT_MOTOR_CW) || (a == iaqs_pkg::ACT_MOTOR_CCW) ||
              (a == iaqs_pkg::ACT_TRIP_RESET) || (a == iaqs_pkg::ACT_COLD_RUN);
    cfg_ok = !(v[iaqs_pkg::CFG_NC_BIT] && no_only) &&
             !(v[iaqs_pkg::CFG_RET_BIT] && a == iaqs_pkg::ACT_TRIP_RESET);
  endfunction : cfg_ok
  // Fieldbus run with no local inputs: both directions at once means off
  function automatic logic [2:0] fb_out(input logic [7:0] c, input logic t);
    logic on_cw;
    logic on_ccw;
    on_cw = c[iaqs_pkg::CTRL_CW] && !c[iaqs_pkg::CTRL_CCW] && !t;
    on_ccw = c[iaqs_pkg::CTRL_CCW] && !c[iaqs_pkg::CTRL_CW] && !t;
    fb_out = {on_cw, on_ccw, (on_cw || on_ccw) && c[iaqs_pkg::CTRL_BRAKE]};
  endfunction : fb_out
  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    close_out();
  end

  initial begin
    seed = 32'h20C2DBE8;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    w(2);
    chk("motor", {cw, ccw, brk, qs, trst, ctrip}, 8'h00);
    bus.rd(iaqs_pkg::REG_CTRL, d);
    chk("ctrl", d, 8'h00);
    bus.rd(iaqs_pkg::REG_STAT, d);
    chk("stat", d, 8'h00);
    bus.rd(4'hF, d);
    chk("unmapped", d, 8'h00);
    done("reset");
    // Normally closed quick stop must not change what the inputs report
    bus.wr(iaqs_pkg::REG_CFG0, 8'h14);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      bus.pins(r[3:0]);
      w(5);
      chk("inputs", {4'h0, ins}, {4'h0, r[3:0]});
    end
    bus.rd(iaqs_pkg::REG_INS, d);
    chk("ins reg", d, {4'h0, r[3:0]});
    done("random inputs");
    bus.wr(iaqs_pkg::REG_CFG0, 8'h24);
    bus.pins(4'h0);
    bus.wr(iaqs_pkg::REG_CTRL, 8'h01);
    w(3);
    chk("cw run", cw, 1'b1);
    bus.pins(4'h1);
    w(5);
    chk("cw qs", cw, 1'b0);
    chk("qs on", qs, 1'b1);
    bus.rd(iaqs_pkg::REG_STAT, d);
    chk("stat qs", d, 8'h08);
    bus.wr(iaqs_pkg::REG_CTRL, 8'h00);
    w(3);
    chk("qs clr", qs, 1'b0);
    bus.wr(iaqs_pkg::REG_CTRL, 8'h01);
    w(3);
    chk("cw static", cw, 1'b1);
    bus.pins(4'h0);
    w(3);
    bus.pins(4'h1);
    w(5);
    chk("cw edge", cw, 1'b0);
    bus.wr(iaqs_pkg::REG_CTRL, 8'h09);
    w(12);
    chk("cw dis", cw, 1'b1);
    bus.pins(4'h0);
    w(3);
    bus.pins(4'h1);
    w(5);
    chk("cw masked", cw, 1'b1);
    bus.wr(iaqs_pkg::REG_CTRL, 8'h08);
    w(3);
    chk("cw revoke", cw, 1'b0);
    done("edge quick stop");
    bus.wr(iaqs_pkg::REG_CFG0, 8'h04);
    bus.wr(iaqs_pkg::REG_CTRL, 8'h01);
    w(5);
    chk("lvl off", cw, 1'b0);
    bus.wr(iaqs_pkg::REG_CTRL, 8'h09);
    w(3);
    chk("lvl dis", cw, 1'b1);
    bus.wr(iaqs_pkg::REG_CTRL, 8'h01);
    w(3);
    chk("lvl undis", cw, 1'b0);
    bus.pins(4'h0);
    w(5);
    chk("lvl rel", cw, 1'b1);
    @(posedge clk) tr <= 1'b1;
    w(3);
    chk("trip", cw, 1'b0);
    @(posedge clk) tr <= 1'b0;
    w(3);
    chk("untrip", cw, 1'b1);
    done("level quick stop");
    // Every refused setting must leave the config at reset and flag the error
    foreach (bad_cfg[i]) begin
      bus.wr(iaqs_pkg::REG_CFG0 + 4'h1, bad_cfg[i]);
      bus.rd(iaqs_pkg::REG_CFG0 + 4'h1, d);
      chk("cfg refused", d, 8'h00);
      bus.rd(iaqs_pkg::REG_STAT, d);
      chk("param err", d[6], 1'b1);
      bus.wr(iaqs_pkg::REG_CTRL, 8'h80);
      bus.rd(iaqs_pkg::REG_STAT, d);
      chk("err clr", d[6], 1'b0);
    end
    done("refusals");
    bus.wr(iaqs_pkg::REG_CFG0, 8'h00);
    bus.wr(iaqs_pkg::REG_CFG0 + 4'h1, 8'h01);
    bus.wr(iaqs_pkg::REG_CFG0 + 4'h2, 8'h22);
    bus.wr(iaqs_pkg::REG_CFG0 + 4'h3, 8'h03);
    // Fieldbus idle here, so only a leaking local input could run the motor
    bus.pins(4'h4);
    w(5);
    chk("no manual", cw, 1'b0);
    bus.wr(iaqs_pkg::REG_CTRL, 8'h01);
    bus.pins(4'h2);
    w(5);
    chk("manual", man, 1'b1);
    chk("bus ignored", cw, 1'b0);
    bus.pins(4'h6);
    w(5);
    chk("local cw", {cw, brk}, 2'b10);
    bus.wr(iaqs_pkg::REG_CTRL, 8'h11);
    w(3);
    chk("local brk", {cw, brk}, 2'b11);
    bus.pins(4'h2);
    w(5);
    chk("retained", cw, 1'b1);
    @(posedge clk) gf <= 1'b1;
    w(3);
    @(posedge clk) gf <= 1'b0;
    w(3);
    chk("fault cancel", cw, 1'b0);
    bus.pins(4'hA);
    w(5);
    chk("local ccw", {ccw, brk}, 2'b11);
    bus.pins(4'h2);
    w(5);
    chk("ccw jog", ccw, 1'b0);
    done("manual local");
    bus.wr(iaqs_pkg::REG_CTRL, 8'h00);
    bus.wr(iaqs_pkg::REG_CFG0 + 4'h1, 8'h00);
    bus.wr(iaqs_pkg::REG_CFG0 + 4'h2, 8'h06);
    bus.wr(iaqs_pkg::REG_CFG0 + 4'h3, 8'h05);
    bus.pins(4'h4);
    w(5);
    chk("cold", {crun, ctrip}, 2'b10);
    @(posedge clk) mc <= 1'b1;
    w(5);
    chk("cold trip", ctrip, 1'b1);
    @(posedge clk) mc <= 1'b0;
    bus.pins(4'h0);
    w(5);
    chk("sticky", {crun, ctrip}, 2'b01);
    n0 = tr_cnt;
    bus.pins(4'h8);
    w(15);
    chk("one reset", tr_cnt - n0, 1);
    chk("trip clr", ctrip, 1'b0);
    done("cold run and trip reset");
    bus.pins(4'h0);
    for (int i = 0; i < 4; i++) begin
      bus.wr(iaqs_pkg::REG_CFG0 + 4'(i), 8'h00);
      cfg_m[i] = 8'h00;
    end
    // No input actions: the fieldbus alone runs the motor, trip blocks it
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      @(posedge clk);
      tr <= r[4];
      mc <= r[5];
      gf <= r[6];
      bus.wr(iaqs_pkg::REG_CTRL, r[15:8]);
      w(3);
      chk("fb run", {cw, ccw, brk}, fb_out(r[15:8], r[4]));
      bus.rd(iaqs_pkg::REG_STAT, d);
      chk("stat trip", d[iaqs_pkg::ST_TRIP], r[4]);
      bus.rd(iaqs_pkg::REG_CTRL, d);
      chk("ctrl back", d, {1'b0, r[14:8]});
    end
    @(posedge clk);
    tr <= 1'b0;
    mc <= 1'b0;
    gf <= 1'b0;
    bus.wr(iaqs_pkg::REG_CTRL, 8'h00);
    done("random fieldbus");
    for (int i = 0; i < 16; i++) begin
      r = $random(seed);
      ok = cfg_ok(r[31:24]);
      bus.wr({2'b00, r[17:16]}, r[31:24]);
      if (ok) cfg_m[r[17:16]] = {2'b00, r[29:24]};
      bus.rd({2'b00, r[17:16]}, d);
      chk("cfg back", d, cfg_m[r[17:16]]);
      bus.rd(iaqs_pkg::REG_STAT, d);
      chk("cfg err", d[iaqs_pkg::ST_PARAM_ERR], !ok);
      bus.wr(iaqs_pkg::REG_CTRL, 8'h80);
      ua = {1'b1, r[22:20]};
      bus.wr(ua, r[7:0]);
      bus.rd(ua, d);
      chk("unmapped rw", d, 8'h00);
    end
    done("random config");
    @(posedge clk);
    rst <= 1'b1;
    w(2);
    @(posedge clk);
    rst <= 1'b0;
    w(2);
    chk("reset out", {cw, ccw, brk, qs, ctrip, crun, man}, 8'h00);
    bus.rd(iaqs_pkg::REG_CFG0, d);
    chk("reset cfg", d, 8'h00);
    done("mid reset");
    close_out();
  end
endmodule : input_action_quick_stop_logic_bench
